// file: phy_status_pkg.sv
// Constants for the physical layer status port.
// Assumes one user clock domain and an active-low asynchronous core reset.
// Contract
// - The first negotiated width is reported on 3 bits: 000 none, 001 x1, 011 x2, 100 x8.
// - The first negotiated width clears on reset or on passing Detect, otherwise holds.
// - The first negotiated width is the widest usable width, capped by both partners.
// - Receive power substate is 00 none, 01 entry, 10 idle, 11 fast training.
// - Transmit power substate is 000 none, 001-011 entry, 100 idle, 101-111 fast training.
// - Lane swap is 00 none, 01 lanes 1:0, 10 lanes 3:0, 11 lanes 7:0.
// - The link fast-rate flag is 1 only when both ends support 5.0 Gb/s.
// - The partner fast-rate flag is 1 when the partner advertises 5.0 Gb/s, valid with link up.
// - The widen-capable flag is 1 when the link can upconfigure, valid with link up.
// - Current rate is 0 for 2.5 Gb/s and 1 for 5.0 Gb/s, valid with link up.
// - Current width is 00 x1, 01 x2, 10 x4, 11 x8, valid with link up.
// - One output tells whether the physical link is up.
// - A found receiver shows 011 on that lane's status with its PHY status strobe.
// - During detection only 000 (absent) and 011 (present) are legal status codes.
// - Raising the detect request starts detection; PHY status marks the result.
package phy_status_pkg;
  localparam logic [2:0] FIRST_W_NONE = 3'h0;
  localparam logic [2:0] FIRST_W_X1   = 3'h1;
  localparam logic [2:0] FIRST_W_X2   = 3'h3;
  localparam logic [2:0] FIRST_W_X8   = 3'h4;
  localparam logic [1:0] CUR_W_X1     = 2'h0;
  localparam logic [1:0] CUR_W_X2     = 2'h1;
  localparam logic [1:0] CUR_W_X4     = 2'h2;
  localparam logic [1:0] CUR_W_X8     = 2'h3;
  localparam logic [1:0] RX_PM_NONE   = 2'h0;
  localparam logic [1:0] RX_PM_ENTRY  = 2'h1;
  localparam logic [1:0] RX_PM_IDLE   = 2'h2;
  localparam logic [1:0] RX_PM_FTS    = 2'h3;
  localparam logic [2:0] TX_PM_NONE   = 3'h0;
  localparam logic [2:0] TX_PM_ENTRY0 = 3'h1;
  localparam logic [2:0] TX_PM_IDLE   = 3'h4;
  localparam logic [2:0] TX_PM_FTS0   = 3'h5;
  localparam logic [2:0] RXST_ABSENT  = 3'h0;
  localparam logic [2:0] RXST_PRESENT = 3'h3;
  localparam int         NUM_LANES    = 4;

  typedef enum logic [2:0] {
    DET_IDLE = 3'b001,
    DET_RUN  = 3'b010,
    DET_DONE = 3'b100
  } det_state_t;

  typedef enum logic [3:0] {
    PM_OFF   = 4'b0001,
    PM_ENTRY = 4'b0010,
    PM_IDLE  = 4'b0100,
    PM_FTS   = 4'b1000
  } pm_state_t;
endpackage

// file: lane_detect.sv
// One lane of receiver detection toward the transceiver wrapper.
// Assumes the detect request from link training is synchronous to mclk.
`timescale 1ns/100ps
module lane_detect
  import phy_status_pkg::*;
#(
  parameter int DET_CYCLES = 4
) (
  input  wire logic       mclk,        // User clock
  input  wire logic       rstn,        // Async reset, active low
  input  wire logic       det_req,     // Detect request from training
  input  wire logic       rx_found,    // Analog result: receiver present
  output logic            phy_status,  // One-cycle done strobe
  output logic [2:0]      rx_status    // Detect result code
);
  det_state_t      st_r, st_nxt;
  logic [7:0]      cnt_r;
  logic            cnt_end;

  assign cnt_end = (cnt_r == 8'(DET_CYCLES - 1));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DET_IDLE: if (det_req) st_nxt = DET_RUN;
      DET_RUN:  if (cnt_end) st_nxt = DET_DONE;
      // Wait for the request to drop before a new run
      DET_DONE: if (!det_req) st_nxt = DET_IDLE;
      default:  st_nxt = DET_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= DET_IDLE;
      cnt_r      <= 8'h00;
      phy_status <= 1'b0;
      rx_status  <= RXST_ABSENT;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= (st_r == DET_RUN) ? cnt_r + 8'h01 : 8'h00;
      phy_status <= (st_r == DET_RUN) && cnt_end;
      // Only the two legal codes are ever produced
      if ((st_r == DET_RUN) && cnt_end)
        rx_status <= rx_found ? RXST_PRESENT : RXST_ABSENT;
      else
        rx_status <= RXST_ABSENT;
    end
  end
endmodule

// file: phy_status_port.sv
// Physical layer status outputs toward the user application.
// Assumes training logic inputs are synchronous to mclk.
`timescale 1ns/100ps
module phy_status_port
  import phy_status_pkg::*;
#(
  parameter int LANES      = NUM_LANES,
  parameter int DET_CYCLES = 4
) (
  input  wire logic             mclk,           // User clock
  input  wire logic             rstn,           // Core reset, active low
  input  wire logic             in_detect,      // Training is in Detect
  input  wire logic             trained,        // Training reached L0
  input  wire logic [1:0]       own_max_width,  // Own width cap, 2-bit code
  input  wire logic [1:0]       ptr_max_width,  // Partner width cap
  input  wire logic [1:0]       lanes_ok_width, // Widest width trained
  input  wire logic [1:0]       width_now,      // Width in use now
  input  wire logic             rate_fast,      // Running at 5.0 Gb/s
  input  wire logic             own_fast,       // Device supports 5.0
  input  wire logic             ptr_fast,       // Partner advertises 5.0
  input  wire logic             can_widen,      // Link can upconfigure
  input  wire logic [1:0]       swap_in,        // Lane reversal found
  input  wire logic             rx_l0s_req,     // Receiver sees L0s entry
  input  wire logic             rx_fts_seen,    // Receiver sees fast train
  input  wire logic             rx_l0s_exit,    // Receiver back in L0
  input  wire logic             tx_l0s_req,     // Transmit L0s request
  input  wire logic             tx_l0s_exit,    // Transmit L0s exit
  input  wire logic             tx_det_rx,      // Receiver detect request
  input  wire logic [LANES-1:0] rx_found,       // Per-lane analog result
  output logic [LANES-1:0]      lane_phy_status, // Per-lane done strobe
  output logic [3*LANES-1:0]    lane_rx_status,  // Per-lane result code
  output logic [2:0]            first_negotiated_width, // First width
  output logic                  phys_link_is_up,        // Link up
  output logic [1:0]            rx_power_substate,      // RX L0s state
  output logic [2:0]            tx_power_substate,      // TX L0s state
  output logic [1:0]            lane_swap_setting,      // Reversal
  output logic                  link_fast_rate_capable, // Both 5.0
  output logic                  partner_fast_rate_capable, // Partner 5.0
  output logic                  link_widen_capable,     // Upconfigure
  output logic                  current_rate,           // Rate now
  output logic [1:0]            current_width           // Width now
);
  // Map the 2-bit width code to the 3-bit first-width code
  function automatic logic [2:0] first_code(input logic [1:0] w);
    case (w)
      CUR_W_X1: first_code = FIRST_W_X1;
      CUR_W_X2: first_code = FIRST_W_X2;
      CUR_W_X8: first_code = FIRST_W_X8;
      default:  first_code = 3'h2; // x4, unnamed in the 3-bit scheme
    endcase
  endfunction

  function automatic logic [1:0] min_w(input logic [1:0] a,
                                       input logic [1:0] b);
    min_w = (a < b) ? a : b;
  endfunction

  // Encode the one-hot receive state as the 2-bit output code
  function automatic logic [1:0] rx_code(input pm_state_t s);
    case (s)
      PM_ENTRY: rx_code = RX_PM_ENTRY;
      PM_IDLE:  rx_code = RX_PM_IDLE;
      PM_FTS:   rx_code = RX_PM_FTS;
      default:  rx_code = RX_PM_NONE;
    endcase
  endfunction

  logic [1:0]  cap_w;
  logic [1:0]  use_w;
  logic        first_hit;
  logic        latched_r;
  logic [2:0]  first_w_nxt;
  pm_state_t   rx_pm_r, rx_pm_nxt;
  logic [1:0]  tx_ph_r, tx_ph_nxt;
  logic [2:0]  tx_pm_nxt;
  logic        tx_in_r, tx_in_nxt;
  logic        tx_fts_r, tx_fts_nxt;
  logic        latch_nxt;
  logic        link_up_nxt;
  logic        both_fast;
  logic [1:0]  rx_code_nxt;

  assign cap_w = min_w(own_max_width, ptr_max_width);
  assign use_w = min_w(cap_w, lanes_ok_width);
  assign first_hit = trained && !latched_r && !in_detect;
  assign first_w_nxt = in_detect ? FIRST_W_NONE :
                       first_hit ? first_code(use_w) :
                       first_negotiated_width;
  // Cleared by Detect so a retrain latches a fresh width
  assign latch_nxt   = in_detect ? 1'b0 : (latched_r | first_hit);
  assign link_up_nxt = trained && !in_detect;
  assign rx_code_nxt = rx_code(rx_pm_nxt);
  assign both_fast   = own_fast && ptr_fast;

  always_comb begin
    rx_pm_nxt = rx_pm_r;
    case (rx_pm_r)
      PM_OFF:   if (rx_l0s_req) rx_pm_nxt = PM_ENTRY;
      PM_ENTRY: rx_pm_nxt = PM_IDLE;
      PM_IDLE:  if (rx_fts_seen) rx_pm_nxt = PM_FTS;
      PM_FTS:   if (rx_l0s_exit) rx_pm_nxt = PM_OFF;
      default:  rx_pm_nxt = PM_OFF;
    endcase
  end

  // Transmit side steps through three entry and three fast-train phases
  always_comb begin
    tx_in_nxt  = tx_in_r;
    tx_fts_nxt = tx_fts_r;
    tx_ph_nxt  = tx_ph_r;
    if (!tx_in_r) begin
      if (tx_l0s_req) begin
        tx_in_nxt = 1'b1;
        tx_ph_nxt = 2'h0;
      end
    end else if (!tx_fts_r && tx_ph_r != 2'h3) begin
      tx_ph_nxt = tx_ph_r + 2'h1; // Entry 0..2 then idle
    end else if (!tx_fts_r) begin
      if (tx_l0s_exit) begin
        tx_fts_nxt = 1'b1;
        tx_ph_nxt  = 2'h0;
      end
    end else if (tx_ph_r != 2'h2) begin
      tx_ph_nxt = tx_ph_r + 2'h1;
    end else begin
      tx_in_nxt  = 1'b0;
      tx_fts_nxt = 1'b0;
      tx_ph_nxt  = 2'h0;
    end
  end

  always_comb begin
    if (!tx_in_nxt)
      tx_pm_nxt = TX_PM_NONE;
    else if (tx_fts_nxt)
      tx_pm_nxt = TX_PM_FTS0 + {1'b0, tx_ph_nxt};
    else if (tx_ph_nxt == 2'h3)
      tx_pm_nxt = TX_PM_IDLE;
    else
      tx_pm_nxt = TX_PM_ENTRY0 + {1'b0, tx_ph_nxt};
  end

  // Reset forces every output to its untrained zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latched_r              <= 1'b0;
      first_negotiated_width <= FIRST_W_NONE;
    end else begin
      latched_r              <= latch_nxt;
      first_negotiated_width <= first_w_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_pm_r <= PM_OFF;
    end else begin
      rx_pm_r <= rx_pm_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_in_r  <= 1'b0;
      tx_fts_r <= 1'b0;
      tx_ph_r  <= 2'h0;
    end else begin
      tx_in_r  <= tx_in_nxt;
      tx_fts_r <= tx_fts_nxt;
      tx_ph_r  <= tx_ph_nxt;
    end
  end

  // Rate and width mean nothing while the link is down; user qualifies
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phys_link_is_up <= 1'b0;
      current_rate    <= 1'b0;
      current_width   <= CUR_W_X1;
    end else begin
      phys_link_is_up <= link_up_nxt;
      current_rate    <= rate_fast;
      current_width   <= width_now;
    end
  end

  // Codes come from the next state so they line up with the state flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_power_substate <= RX_PM_NONE;
      tx_power_substate <= TX_PM_NONE;
    end else begin
      rx_power_substate <= rx_code_nxt;
      tx_power_substate <= tx_pm_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lane_swap_setting         <= 2'h0;
      link_fast_rate_capable    <= 1'b0;
      partner_fast_rate_capable <= 1'b0;
      link_widen_capable        <= 1'b0;
    end else begin
      lane_swap_setting         <= swap_in;
      link_fast_rate_capable    <= both_fast;
      partner_fast_rate_capable <= ptr_fast;
      link_widen_capable        <= can_widen;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      lane_detect #(.DET_CYCLES(DET_CYCLES)) u_det (
        .mclk       (mclk),
        .rstn       (rstn),
        .det_req    (tx_det_rx),
        .rx_found   (rx_found[g]),
        .phy_status (lane_phy_status[g]),
        .rx_status  (lane_rx_status[3*g +: 3])
      );
    end
  endgenerate
endmodule

// file: phy_status_props.sv
// Checker on the status port pins.
// Bound to phy_status_port; sees its ports only.
`timescale 1ns/100ps
module phy_status_props
  import phy_status_pkg::*;
#(parameter int LANES = NUM_LANES, parameter int DET_CYCLES = 4) (
  input wire logic               mclk,            // Clock
  input wire logic               rstn,            // Reset
  input wire logic               in_detect,       // Detect
  input wire logic               trained,         // In L0
  input wire logic               rate_fast,       // Rate in
  input wire logic               tx_det_rx,       // Detect req
  input wire logic [LANES-1:0]   rx_found,        // Found
  input wire logic [LANES-1:0]   lane_phy_status, // Done
  input wire logic [3*LANES-1:0] lane_rx_status,  // Code
  input wire logic [2:0]         first_negotiated_width, // First
  input wire logic               phys_link_is_up, // Up
  input wire logic               current_rate     // Rate
);
  localparam int DLO = DET_CYCLES + 1;
  localparam int DHI = DET_CYCLES + 2;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // First edge after reset sees reset-time inputs, so it is skipped
  a_link_up_level: assert property ($past(rstn) |->
    phys_link_is_up == $past(trained && !in_detect)) else $error("link up");
  a_rate_follows: assert property ($past(rstn) |->
    current_rate == $past(rate_fast)) else $error("rate");
  a_first_clear: assert property ($past(rstn) && $past(in_detect) |->
    first_negotiated_width == FIRST_W_NONE) else $error("first clear");
  a_first_holds: assert property ($past(rstn) && !$past(in_detect) &&
    $past(first_negotiated_width) != 3'h0 |-> $stable(first_negotiated_width))
    else $error("first hold");
  a_det_single: assert property (lane_phy_status[0] |=>
    !lane_phy_status[0]) else $error("done pulse");
  a_det_result: assert property (lane_phy_status[0] |->
    lane_rx_status[2:0] == ($past(rx_found[0]) ? RXST_PRESENT : RXST_ABSENT))
    else $error("detect code");
  a_det_quiet: assert property (!lane_phy_status[0] |->
    lane_rx_status[2:0] == RXST_ABSENT) else $error("code outside done");
  a_det_timing: assert property ($rose(tx_det_rx) |->
    ##[DLO:DHI] lane_phy_status[0]) else $error("detect time");
  c_found: cover property (lane_phy_status[0] && lane_rx_status[2:0] == 3'h3);
  c_first_x8: cover property (first_negotiated_width == FIRST_W_X8);
  c_fast_up: cover property (current_rate && phys_link_is_up);
endmodule
bind phy_status_port phy_status_props #(.LANES(LANES), .DET_CYCLES(DET_CYCLES))
  i_props (.mclk, .rstn, .in_detect, .trained, .rate_fast, .tx_det_rx,
  .rx_found, .lane_phy_status, .lane_rx_status, .first_negotiated_width,
  .phys_link_is_up, .current_rate);

// file: link_watch.sv
// User side status keeper, sampling only while link is up.
// Assumes inputs are the port's registered outputs.
`timescale 1ns/100ps
module link_watch (
  input  wire logic       mclk,   // Clock
  input  wire logic       rstn,   // Reset, active low
  input  wire logic       up,     // Link up
  input  wire logic       rate,   // Current rate
  input  wire logic [1:0] width,  // Current width
  output logic            rate_r, // Rate kept
  output logic [1:0]      width_r // Width kept
);
  // Values outside link up mean nothing; keep the last good pair
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rate_r  <= 1'h0;
      width_r <= 2'h0;
    end else if (up) begin
      rate_r  <= rate;
      width_r <= width;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench for the physical layer status port.
// Assumes package, checker and link_watch are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench import phy_status_pkg::*; ();
  localparam int DC = 3;
  int tests_run = 0, n_fail = 0, cyc = 0;
  logic mclk = 1'h0, rstn = 1'h0, in_detect = 1'h0, trained = 1'h0;
  logic rate_fast = 1'h1, own_fast = 1'h1, ptr_fast = 1'h1, can_widen = 1'h1;
  logic tx_det_rx = 1'h0, seen_rate, current_rate, phys_link_is_up;
  logic link_fast_rate_capable, partner_fast_rate_capable, link_widen_capable;
  logic rx_l0s_req, rx_fts_seen, rx_l0s_exit, tx_l0s_req, tx_l0s_exit;
  logic [4:0] pm = 5'h0;
  logic [1:0] own_max_width = 2'h0, ptr_max_width = 2'h0, lanes_ok_width = 2'h0;
  logic [1:0] width_now = 2'h3, swap_in = 2'h3, rx_power_substate, seen_width;
  logic [1:0] lane_swap_setting, current_width;
  logic [3:0] rx_found = 4'h0, lane_phy_status;
  logic [11:0] lane_rx_status;
  logic [2:0] first_negotiated_width, tx_power_substate;
  logic [8:0] fw_tab [4] = '{9'h1FC, 9'h1BB, 9'h079, 9'h1F2};
  assign {rx_l0s_req, rx_fts_seen, rx_l0s_exit, tx_l0s_req, tx_l0s_exit} = pm;
  phy_status_port #(.DET_CYCLES(DC)) i_dut (.mclk, .rstn, .in_detect, .trained,
    .own_max_width, .ptr_max_width, .lanes_ok_width, .width_now, .rate_fast,
    .own_fast, .ptr_fast, .can_widen, .swap_in, .rx_l0s_req, .rx_fts_seen,
    .rx_l0s_exit, .tx_l0s_req, .tx_l0s_exit, .tx_det_rx, .rx_found,
    .lane_phy_status, .lane_rx_status, .first_negotiated_width,
    .phys_link_is_up, .rx_power_substate, .tx_power_substate,
    .lane_swap_setting, .link_fast_rate_capable, .partner_fast_rate_capable,
    .link_widen_capable, .current_rate, .current_width);
  link_watch i_watch (.mclk, .rstn, .up(phys_link_is_up), .rate(current_rate),
    .width(current_width), .rate_r(seen_rate), .width_r(seen_width));
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 2000) begin n_fail++; end_sim(); end
  task automatic end_sim();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(int b);
    @(posedge mclk);
    pm[b] <= 1'h1;
    @(posedge mclk);
    pm[b] <= 1'h0;
  endtask
  // Polls a power substate, bounded, then compares it
  task automatic await_pm(bit tx, logic [2:0] v);
    int w = 0;
    #1;
    while ((tx ? tx_power_substate : {1'h0, rx_power_substate}) !== v && w++ < 8)
      tick(1);
    `CHK(tx ? tx_power_substate : {1'h0, rx_power_substate}, v)
  endtask
  task automatic detect(logic [3:0] found);
    int w = 0;
    @(posedge mclk);
    rx_found <= found;
    tx_det_rx <= 1'h1;
    do begin tick(1); w++; end while (lane_phy_status === 4'h0 && w < 40);
    `CHK(w, DC + 1)
    `CHK(lane_phy_status, 4'hF)
    for (int g = 0; g < 4; g++)
      `CHK(lane_rx_status[3*g +: 3], found[g] ? RXST_PRESENT : RXST_ABSENT)
    // Request still high: no second run may start
    repeat (6) begin tick(1); `CHK({lane_phy_status, lane_rx_status}, 16'h0) end
    @(posedge mclk);
    tx_det_rx <= 1'h0;
  endtask
  initial begin
    tick(5);
    `CHK({first_negotiated_width, phys_link_is_up, current_width}, 6'h0)
    `CHK({link_fast_rate_capable, current_rate, lane_swap_setting}, 4'h0)
    @(posedge mclk);
    rstn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {own_fast, ptr_fast} <= i[1:0];
      {rate_fast, width_now, swap_in, can_widen} <= {i[0], i[1:0], i[1:0], i[1]};
      tick(1);
      `CHK({link_fast_rate_capable, partner_fast_rate_capable}, {i == 3, i[0]})
      `CHK({current_rate, current_width}, {i[0], i[1:0]})
      `CHK({lane_swap_setting, link_widen_capable}, {i[1:0], i[1]})
    end
    $display("flags test done");
    foreach (fw_tab[k]) begin
      @(posedge mclk);
      {own_max_width, ptr_max_width, lanes_ok_width} <= fw_tab[k][8:3];
      {in_detect, trained} <= 2'h1;
      tick(2);
      `CHK({first_negotiated_width, phys_link_is_up}, {fw_tab[k][2:0], 1'h1})
      @(posedge mclk);
      lanes_ok_width <= 2'h0;
      tick(2);
      `CHK(first_negotiated_width, fw_tab[k][2:0])
      @(posedge mclk);
      in_detect <= 1'h1;
      tick(1);
      `CHK({first_negotiated_width, phys_link_is_up}, 4'h0)
    end
    @(posedge mclk);
    {rate_fast, width_now} <= 3'h1;
    tick(2);
    `CHK({seen_rate, seen_width, current_width}, 5'h1D)
    $display("first width test done");
    detect(4'h5);
    detect(4'hA);
    $display("detect test done");
    @(posedge mclk);
    in_detect <= 1'h0;
    pulse(1);
    for (int v = 1; v < 5; v++) await_pm(1, v[2:0]);
    tick(3);
    await_pm(1, TX_PM_IDLE);
    pulse(0);
    for (int v = 5; v < 9; v++) await_pm(1, v[2:0]);
    pulse(4);
    await_pm(0, 3'h1);
    await_pm(0, 3'h2);
    pulse(3);
    await_pm(0, 3'h3);
    pulse(2);
    await_pm(0, 3'h0);
    $display("power state test done");
    end_sim();
  end
endmodule
